// [src/bcc_cfg.svh]
// Purpose: constants of the bridge control configuration block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH

`define BCC_STATUS_OFS 8'h50
`define BCC_CONFIG_OFS 8'h54

`define BCC_CFG_OUTSIDE_CTL_BIT 7
`define BCC_CFG_RX_IRQ_EN_BIT 6
`define BCC_CFG_REM_LOAD_OFF_BIT 5
`define BCC_CFG_AUTOSTART_OFF_BIT 4
`define BCC_CFG_PROT_AUTO_OFF_BIT 3

`define BCC_STS_RX5V_BIT 7
`define BCC_STS_RX_IRQ_BIT 6
`define BCC_STS_PROT_IRQ_BIT 5
`define BCC_STS_INIT_DONE_BIT 4
`define BCC_STS_REM_LOADED_BIT 3
`define BCC_STS_CFG_DONE_BIT 2
`define BCC_STS_CFG_CKSUM_BIT 1
`define BCC_STS_ID_CKSUM_BIT 0

`define BCC_CONFIG_RESET 8'h00
`define BCC_CONFIG_RW_MASK 8'hf8
`define BCC_UNMAPPED_READ 8'h00
`define BCC_RDATA_RESET 8'h00
`define BCC_PIN_IDLE 1'b1

`endif

// [src/bcc_pkg.sv]
// Purpose: shared types of the bridge control configuration block
// Assumes: nothing beyond the cfg header
// Notes: gray codes along the normal start-up path
package bcc_pkg;
    typedef enum logic [2:0] {
        BCC_IDLE = 3'h0,
        BCC_ID_LOAD = 3'h1,
        BCC_RX_INIT = 3'h3,
        BCC_PROT_PROG = 3'h2,
        BCC_DONE = 3'h6
    } bcc_state_t;
endpackage

// [src/bcc_seq_if.sv]
// Purpose: carrier between register bank and bridge control sequencer
// Assumes: single clock domain
// Notes: req signals are levels, done signals one-cycle pulses
`timescale 1ns/1ns
interface bcc_seq_if;
    logic run;
    logic rem_load_off;
    logic autostart_off;
    logic prot_auto_off;
    logic id_load_req;
    logic id_load_done;
    logic rx_init_req;
    logic rx_init_done;
    logic prot_req;
    logic prot_done;
    logic cfg_done_flag;
    logic init_done_flag;
    logic rem_loaded_set;

    modport seq (
        input run, rem_load_off, autostart_off, prot_auto_off,
        input id_load_done, rx_init_done, prot_done,
        output id_load_req, rx_init_req, prot_req,
        output cfg_done_flag, init_done_flag, rem_loaded_set
    );
    modport ctl (
        output run, rem_load_off, autostart_off, prot_auto_off,
        output id_load_done, rx_init_done, prot_done,
        input id_load_req, rx_init_req, prot_req,
        input cfg_done_flag, init_done_flag, rem_loaded_set
    );
endinterface

// [src/bcc_seq.sv]
// Purpose: internal bridge control start-up sequencer
// Assumes: engines answer each request with a one-cycle done pulse
// Notes: dropping run aborts at once and the sequence restarts later
`timescale 1ns/1ns
module bcc_seq
    import bcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    bcc_seq_if.seq sq
);
    bcc_state_t state;
    bcc_state_t next_state;
    logic cfg_done;
    logic next_cfg_done;

    always_comb
    begin
        next_state = state;
        next_cfg_done = cfg_done;
        if (!sq.run)
        begin
            // outside controller owns receiver and protection setup, see R1
            next_state = BCC_IDLE;
            next_cfg_done = 1'b0;
        end
        else
        begin
            case (state)
                BCC_IDLE:
                begin
                    if (!sq.rem_load_off)
                        next_state = BCC_ID_LOAD; // see R7
                    else
                    begin
                        next_state = BCC_RX_INIT; // skip remote load, see R8
                        next_cfg_done = 1'b1;
                    end
                end
                BCC_ID_LOAD:
                begin
                    if (sq.id_load_done)
                    begin
                        next_state = BCC_RX_INIT;
                        next_cfg_done = 1'b1;
                    end
                end
                BCC_RX_INIT:
                begin
                    if (sq.autostart_off || sq.rx_init_done)
                        next_state = BCC_PROT_PROG; // see R9
                end
                BCC_PROT_PROG:
                begin
                    if (sq.prot_auto_off || sq.prot_done)
                        next_state = BCC_DONE; // see R11
                end
                default:
                    next_state = BCC_DONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= BCC_IDLE;
            cfg_done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cfg_done <= next_cfg_done;
        end
    end

    // requests gated by run so nothing starts under outside control, see R2
    assign sq.id_load_req = sq.run && (state == BCC_ID_LOAD);
    assign sq.rx_init_req = sq.run && (state == BCC_RX_INIT) && !sq.autostart_off; // see R9
    assign sq.prot_req = sq.run && (state == BCC_PROT_PROG) && !sq.prot_auto_off; // see R12
    assign sq.rem_loaded_set = sq.run && (state == BCC_ID_LOAD) && sq.id_load_done; // see R14
    assign sq.cfg_done_flag = cfg_done;
    assign sq.init_done_flag = (state == BCC_DONE);
endmodule

// [src/bcc_top.sv]
// Purpose: bridge control configuration and status registers with start-up control
// Assumes: register port and all pins synchronous to clk
// Notes: interrupt pin is active low and follows the receiver pending level while bit 6 is set
//
// Overview of operation
// R1: outside control bit 7 set disables internal bridge control sequencing.
// R2: under outside control, no receiver init or protection start by device.
// R3: outside controller on the serial port does init and protection itself.
// R4: strap pin loads bits 7 and 5 at power-up.
// R5: bit 6 gates receiver interrupts onto the interrupt pin.
// R6: software reads status to find whether receiver or protection interrupted.
// R7: remote load enabled: fetch identification data from remote EEPROM.
// R8: bit 5 set skips the remote identification load.
// R9: receiver auto-initialised unless bit 4 set.
// R10: with bit 4 set, EEPROM config or outside controller initialises receiver.
// R11: by default device programs receiver protection control register.
// R12: bit 3 set stops automatic protection control register writes.
// R13: status at 0x50 shows receiver interrupt pending at bit 6.
// R14: status bit 3 set once remote identification load completes.
// R15: interrupt pin asserted while enabled receiver interrupt pending.
`timescale 1ns/1ns
`include "bcc_cfg.svh"
module bcc_top
    import bcc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic second_strap_pin,
    input wire logic rx5v_detect,
    input wire logic rx_irq_pending,
    input wire logic prot_irq_pending,
    input wire logic id_checksum_ok,
    output logic id_load_start,
    input wire logic id_load_done,
    output logic rx_init_start,
    input wire logic rx_init_done,
    output logic prot_prog_start,
    input wire logic prot_prog_done,
    output logic interrupt_output_pin_n
);
    bcc_seq_if sq ();

    logic [7:0] config_reg;
    logic [7:0] next_config_reg;
    logic strap_taken;
    logic next_strap_taken;
    logic rem_loaded;
    logic next_rem_loaded;
    logic id_cksum;
    logic next_id_cksum;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic irq_n;
    logic next_irq_n;
    logic [7:0] status_now;

    // config register with strap capture at the first edge after reset release
    always_comb
    begin
        next_config_reg = config_reg;
        next_strap_taken = 1'b1;
        if (!strap_taken)
        begin
            // writes in this cycle are dropped so the strap always lands, see R4
            next_config_reg[`BCC_CFG_OUTSIDE_CTL_BIT] = second_strap_pin; // see R4
            next_config_reg[`BCC_CFG_REM_LOAD_OFF_BIT] = second_strap_pin; // see R4
        end
        else if (reg_wr && (reg_addr == `BCC_CONFIG_OFS))
            next_config_reg = reg_wdata & `BCC_CONFIG_RW_MASK;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            config_reg <= `BCC_CONFIG_RESET;
            strap_taken <= 1'b0;
        end
        else
        begin
            config_reg <= next_config_reg;
            strap_taken <= next_strap_taken;
        end
    end

    // sequencer hookup
    assign sq.run = strap_taken && !config_reg[`BCC_CFG_OUTSIDE_CTL_BIT]; // see R1
    assign sq.rem_load_off = config_reg[`BCC_CFG_REM_LOAD_OFF_BIT]; // see R8
    assign sq.autostart_off = config_reg[`BCC_CFG_AUTOSTART_OFF_BIT]; // see R9
    assign sq.prot_auto_off = config_reg[`BCC_CFG_PROT_AUTO_OFF_BIT]; // see R12
    assign sq.id_load_done = id_load_done;
    assign sq.rx_init_done = rx_init_done;
    assign sq.prot_done = prot_prog_done;

    bcc_seq u_seq (
        .clk(clk),
        .nrst(nrst),
        .sq(sq)
    );

    // handshake requests are combinational from the sequencer state
    assign id_load_start = sq.id_load_req;
    assign rx_init_start = sq.rx_init_req; // see R2
    assign prot_prog_start = sq.prot_req; // see R2

    // remote load flag held until reset; checksum result from the latest completed load
    always_comb
    begin
        next_rem_loaded = rem_loaded;
        next_id_cksum = id_cksum;
        if (sq.rem_loaded_set)
        begin
            next_rem_loaded = 1'b1; // see R14
            next_id_cksum = id_checksum_ok;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rem_loaded <= 1'b0;
            id_cksum <= 1'b0;
        end
        else
        begin
            rem_loaded <= next_rem_loaded;
            id_cksum <= next_id_cksum;
        end
    end

    // live status view; pending bits come straight from their sources, see R6
    always_comb
    begin
        status_now = 8'h00;
        status_now[`BCC_STS_RX5V_BIT] = rx5v_detect;
        status_now[`BCC_STS_RX_IRQ_BIT] = rx_irq_pending; // see R13
        status_now[`BCC_STS_PROT_IRQ_BIT] = prot_irq_pending; // see R6
        status_now[`BCC_STS_INIT_DONE_BIT] = sq.init_done_flag;
        status_now[`BCC_STS_REM_LOADED_BIT] = rem_loaded; // see R14
        status_now[`BCC_STS_CFG_DONE_BIT] = sq.cfg_done_flag;
        status_now[`BCC_STS_CFG_CKSUM_BIT] = 1'b0;
        status_now[`BCC_STS_ID_CKSUM_BIT] = id_cksum;
    end

    // registered read data, one cycle after the read strobe
    // holding the last value keeps the port quiet between reads
    always_comb
    begin
        next_rdata = rdata;
        if (reg_rd)
        begin
            if (reg_addr == `BCC_STATUS_OFS)
                next_rdata = status_now; // see R13
            else if (reg_addr == `BCC_CONFIG_OFS)
                next_rdata = config_reg;
            else
                next_rdata = `BCC_UNMAPPED_READ;
        end
    end

    // interrupt pin registered; only the receiver source is gated here
    always_comb
    begin
        next_irq_n = !(config_reg[`BCC_CFG_RX_IRQ_EN_BIT] && rx_irq_pending); // see R5 and R15
    end

    // registered so the pin never glitches on a config write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_n <= `BCC_PIN_IDLE;
        end
        else
        begin
            irq_n <= next_irq_n;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= `BCC_RDATA_RESET;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata = rdata;
    assign interrupt_output_pin_n = irq_n;
endmodule

// [tb/bcc_top_assertions.sv]
// Purpose: port checker for bcc_top
// Assumes: shadow config tracks strap and writes
// Notes: bind at foot
`timescale 1ns/1ns
`include "bcc_cfg.svh"
module bcc_top_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic second_strap_pin,
    input wire logic rx_irq_pending,
    input wire logic id_load_start,
    input wire logic id_load_done,
    input wire logic rx_init_start,
    input wire logic prot_prog_start,
    input wire logic interrupt_output_pin_n
);
    logic [7:0] cfg;
    logic first;
    logic wr_cfg;
    logic [2:0] st;
    logic irq;
    assign wr_cfg = reg_wr && reg_addr == `BCC_CONFIG_OFS;
    assign st = {prot_prog_start, rx_init_start, id_load_start};
    assign irq = cfg[6] && rx_irq_pending;
    // strap edge wins over any write, as in the device
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            {first, cfg} <= 9'h100;
        else if (first)
            {first, cfg} <= {1'b0, second_strap_pin, 1'b0, second_strap_pin, 5'h00};
        else if (wr_cfg)
            cfg <= reg_wdata & `BCC_CONFIG_RW_MASK;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_ext_no_start: assert property (cfg[7] |-> st == 3'h0)
        else $error("start under outside control");
    a_irq_pin_on: assert property (irq |=> !interrupt_output_pin_n)
        else $error("pin not low");
    a_irq_pin_off: assert property (!irq |=> interrupt_output_pin_n)
        else $error("pin not high");
    a_load_skip: assert property ($rose(id_load_start) |-> !cfg[5])
        else $error("load while off");
    a_init_skip: assert property ($rose(rx_init_start) |-> !cfg[4])
        else $error("init while off");
    a_prot_skip: assert property ($rose(prot_prog_start) |-> !cfg[3])
        else $error("prot while off");
    a_load_hold: assert property (id_load_start && !id_load_done && !wr_cfg |=> id_load_start)
        else $error("load request dropped");
    a_one_request: assert property ($onehot0(st))
        else $error("two requests");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule
bind bcc_top bcc_top_chk u_chk (.clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .second_strap_pin, .rx_irq_pending, .id_load_start, .id_load_done, .rx_init_start,
    .prot_prog_start, .interrupt_output_pin_n);

// [tb/bcc_engine_model.sv]
// Purpose: engine answering a start level with a done pulse
// Assumes: start held until done
// Notes: slow mode leaves room to abort mid-request
`timescale 1ns/1ns
module bcc_engine_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic slow,
    output logic done
);
    logic [3:0] cnt;
    // done lasts one cycle, start falls after it
    always @(negedge clk or negedge nrst)
    begin
        if (!nrst || !start || done)
            {cnt, done} <= 5'h00;
        else
            {cnt, done} <= {cnt + 4'h1, cnt == (slow ? 4'h8 : 4'h1)};
    end
endmodule

// [tb/bcc_top_tb_top.sv]
// Purpose: self-checking bench for bcc_top
// Assumes: engine models answer the starts
// Notes: inputs move on the falling edge
`timescale 1ns/1ns
module bcc_top_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rxirq = 1'b0;
    logic slow = 1'b0;
    logic [7:0] rdata;
    logic [7:0] got;
    logic strap = 1'b1;
    logic prot = 1'b1;
    wire [2:0] st;
    wire [2:0] dn;
    logic pin_n;
    int miscompares = 0;
    int checks = 0;
    // waddr, wdata, raddr, expected read
    logic [31:0] rows [5] = '{32'h555a54a0, 32'h54a754a0, 32'h54ff54f8, 32'h50ff50a0, 32'h55005500};

    bcc_top dut (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .second_strap_pin(strap), .rx5v_detect(1'b1),
        .rx_irq_pending(rxirq), .prot_irq_pending(prot), .id_checksum_ok(1'b1),
        .id_load_start(st[0]), .id_load_done(dn[0]), .rx_init_start(st[1]), .rx_init_done(dn[1]),
        .prot_prog_start(st[2]), .prot_prog_done(dn[2]), .interrupt_output_pin_n(pin_n));
    for (genvar g = 0; g < 3; g++)
    begin : eng
        bcc_engine_model u_eng (.clk(clk), .nrst(nrst), .start(st[g]), .slow(slow), .done(dn[g]));
    end

    initial forever #2 clk = ~clk;

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        got = rdata;
    endtask
    task automatic wait_for(input int k, input logic v);
        int n = 0;
        while (st[k] !== v && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, st[k]}, {7'h00, v});
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #40000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(rows[i][31:24], rows[i][23:16]);
            rd_reg(rows[i][15:8]);
            chk(got, rows[i][7:0]);
        end
        chk({5'h00, st}, 8'h00);
        wr_reg(8'h54, 8'h00);
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        rd_reg(8'h50);
        chk(got, 8'hbd);
        rxirq = 1'b1;
        wr_reg(8'h54, 8'h40);
        repeat (2) @(negedge clk);
        chk({7'h00, pin_n}, 8'h00);
        rd_reg(8'h50);
        chk(got, 8'hfd);
        rxirq = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, pin_n}, 8'h01);
        prot = 1'b0;
        rd_reg(8'h50);
        chk(got, 8'h9d);
        wr_reg(8'h54, 8'h00);
        rxirq = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, pin_n}, 8'h01);
        rxirq = 1'b0;
        // every stage off: sequence must finish with no request
        wr_reg(8'h54, 8'h80);
        wr_reg(8'h54, 8'h38);
        got = 8'h00;
        for (int i = 0; i < 10 && got[4] !== 1'b1; i++)
            rd_reg(8'h50);
        chk(got & 8'h10, 8'h10);
        // abort while the load request is held
        slow = 1'b1;
        wr_reg(8'h54, 8'h80);
        wr_reg(8'h54, 8'h00);
        wait_for(0, 1'b1);
        wr_reg(8'h54, 8'h80);
        chk({5'h00, st}, 8'h00);
        rd_reg(8'h50);
        chk(got & 8'h14, 8'h00);
        // mid-run reset with strap low; a write on the strap edge is lost
        @(negedge clk);
        {nrst, strap} = 2'b00;
        repeat (3) @(negedge clk);
        chk({7'h00, pin_n}, 8'h01);
        chk(rdata, 8'h00);
        {nrst, addr, wdata, wr} = {1'b1, 8'h54, 8'h40, 1'b1};
        @(negedge clk);
        wr = 1'b0;
        rd_reg(8'h54);
        chk(got, 8'h00);
        wait_for(0, 1'b1);
        print_verdict();
    end
endmodule
